//--- verilog/ddcs_top.sv
// drive control decode, markers, fault and positioning status
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module ddcs_top #(
  parameter int unsigned OFFSET_SETTLE_CYC = ddcs_pkg::OFFSET_MAX_CYC / 2,
  parameter int unsigned ZERO_SEEK_CYC     = ddcs_pkg::ZERO_SEEK_MAX_CYC / 2,
  parameter int unsigned HEAD_SEEK_CYC     = ddcs_pkg::HEAD_SEEK_MAX_CYC / 2,
  parameter int unsigned MOVE_TIMEOUT_CYC  = ddcs_pkg::MOVE_MAX_CYC,
  parameter int unsigned REV_CYC           = ddcs_pkg::REV_CYC
) (
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [3:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // controller tags and bus
  input  wire logic                      cyl_tag_i,
  input  wire logic                      head_tag_i,
  input  wire logic                      ctl_tag_i,
  input  wire logic [9:0]                bus_i,
  // drive hardware conditions
  input  wire ddcs_pkg::ddcs_hw_type     hw_i,
  // positioner and read/write chain
  output logic                           move_start_o,
  output logic      [9:0]                move_cyl_o,
  output logic      [1:0]                head_o,
  output logic                           write_drive_o,
  output logic                           read_data_en_o,
  output logic                           read_sync_start_o,
  output logic                           strobe_early_o,
  output logic                           strobe_late_o,
  // controller status lines
  output ddcs_pkg::ddcs_status_type      status_o,
  output logic                           rev_mark_o,
  output logic                           sector_mark_o
);
  import ddcs_pkg::*;

  typedef enum {POS_IDLE, POS_MOVE, POS_SETTLE} ddcs_pos_type;

  if (REV_CYC < 4 * SECT_FULL * MARK_CYC || OFFSET_SETTLE_CYC < 1 ||
      ZERO_SEEK_CYC < 1 || HEAD_SEEK_CYC < 1 || MOVE_TIMEOUT_CYC < 1)
    $error("ddcs_top: timing parameters out of range");

  localparam int unsigned PIN_W = 13 + $bits(ddcs_hw_type);

  // width measure: saturating count of cycles a level has been high
  function automatic logic [3:0] width_cnt(input logic lvl,
                                           input logic [3:0] c);
    if (!lvl)
      width_cnt = 4'h0;
    else if (c == 4'hf)
      width_cnt = c;
    else
      width_cnt = c + 4'h1;
  endfunction

  logic [PIN_W-1:0] pins;
  logic             tag1;
  logic             tag2;
  logic             tag3;
  logic [9:0]       bus;
  ddcs_hw_type      hw;
  logic [9:0]       cb;
  logic [9:0]       cb_q;
  logic             tag1_q;
  logic             tag2_q;
  logic             move_done_q;
  logic             seek_ok;
  logic [3:0]       clr_w;
  logic [3:0]       home_w;
  logic             clr_fire;
  logic             home_fire;
  logic             offset_chg;
  logic [9:0]       cyl;
  logic [9:0]       tgt;
  logic [1:0]       head;
  logic [1:0]       head_next;
  logic             head_pending;
  logic             head_chg;
  logic             home_run;
  ddcs_pos_type     pos;
  logic [31:0]      pos_cnt;
  logic             seek_err;
  logic             fault;
  logic             retract;
  logic [7:0]       cause;
  logic [7:0]       next_cause;
  logic             hw_cause;
  logic             wen;
  logic             ren;
  logic [1:0]       ctrl;
  logic [31:0]      rev_cnt;
  logic [31:0]      sect_len;
  logic [31:0]      sect_cnt;
  logic [5:0]       mark_cnt;
  logic             mark_start;

  // synchronise every pin
  ddcs_sync #(.W(PIN_W)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({cyl_tag_i, head_tag_i, ctl_tag_i, bus_i, hw_i}),
    .q_o   (pins)
  );
  assign {tag1, tag2, tag3, bus, hw} = pins;

  // control functions are the bus qualified by the control strobe
  assign cb  = tag3 ? (bus & 10'h1df) : 10'h000;
  assign wen = cb[BIT_WRITE];
  assign ren = cb[BIT_READ];

  // edge history and pulse widths
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cb_q   <= 10'h000;
      tag1_q <= 1'b0;
      tag2_q <= 1'b0;
      clr_w  <= 4'h0;
      home_w <= 4'h0;
      move_done_q <= 1'b0;
    end
    else
    begin
      cb_q   <= cb;
      tag1_q <= tag1;
      tag2_q <= tag2;
      clr_w  <= width_cnt(cb[BIT_FAULT_CLR], clr_w);
      home_w <= width_cnt(cb[BIT_HOME], home_w);
      move_done_q <= hw.move_done; // arrival counts on its rise only
    end
  end

  // a pulse counts once it has lasted the least width
  assign clr_fire   = cb[BIT_FAULT_CLR] && clr_w == 4'(MIN_PULSE_CYC - 1);
  assign home_fire  = cb[BIT_HOME] && home_w == 4'(MIN_PULSE_CYC - 1);
  assign offset_chg = (cb[BIT_OFS_PLUS] != cb_q[BIT_OFS_PLUS]) ||
                      (cb[BIT_OFS_MINUS] != cb_q[BIT_OFS_MINUS]);

  // read chain controls; servo area stays out of reach
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      read_data_en_o    <= 1'b0;
      read_sync_start_o <= 1'b0;
      strobe_early_o    <= 1'b0;
      strobe_late_o     <= 1'b0;
      write_drive_o     <= 1'b0;
    end
    else
    begin
      read_data_en_o    <= ren && !hw.servo_area;
      read_sync_start_o <= ren && !cb_q[BIT_READ];
      strobe_early_o    <= ren && cb[BIT_EARLY];
      strobe_late_o     <= ren && cb[BIT_LATE];
      write_drive_o     <= wen && !fault && !hw.servo_area &&
                           !hw.write_protect;
    end
  end

  // head select waits for the following seek
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      head_next    <= 2'h0;
      head_pending <= 1'b0;
    end
    else if (home_fire && pos == POS_IDLE)
      head_pending <= 1'b0;
    else if (tag2 && !tag2_q)
    begin
      head_next    <= bus[1:0];
      head_pending <= 1'b1;
    end
    else if (tag1_q && !tag1 && seek_ok)
      head_pending <= 1'b0;
  end

  // seek gate sampled once, at the rise of the cylinder strobe
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      seek_ok <= 1'b0;
    else if (tag1 && !tag1_q)
      seek_ok <= status_o.heads_positioned && !seek_err && !fault;
  end

  // positioner sequencing, error and heads-positioned
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pos          <= POS_IDLE;
      pos_cnt      <= 32'h0;
      cyl          <= 10'h000;
      tgt          <= 10'h000;
      head         <= 2'h0;
      head_chg     <= 1'b0;
      home_run     <= 1'b0;
      seek_err     <= 1'b0;
      move_start_o <= 1'b0;
    end
    else
    begin
      move_start_o <= 1'b0;
      case (pos)
        POS_IDLE:
        begin
          if (home_fire)
          begin
            seek_err     <= 1'b0;
            tgt          <= 10'h000;
            head_chg     <= head != 2'h0;
            head         <= 2'h0;
            home_run     <= 1'b1;
            move_start_o <= 1'b1;
            pos_cnt      <= 32'(MOVE_TIMEOUT_CYC);
            pos          <= POS_MOVE;
          end
          else if (tag1_q && !tag1 && seek_ok)
          begin
            if (bus > MAX_CYL)
              seek_err <= 1'b1;
            else
            begin
              tgt      <= bus;
              head_chg <= head != head_next;
              head     <= head_next;
              if (bus == cyl)
              begin
                pos_cnt <= (head != head_next) ? 32'(HEAD_SEEK_CYC)
                                               : 32'(ZERO_SEEK_CYC);
                pos     <= POS_SETTLE;
              end
              else
              begin
                move_start_o <= 1'b1;
                pos_cnt      <= 32'(MOVE_TIMEOUT_CYC);
                pos          <= POS_MOVE;
              end
            end
          end
          else if (offset_chg)
          begin
            pos_cnt <= 32'(OFFSET_SETTLE_CYC);
            pos     <= POS_SETTLE;
          end
        end
        POS_MOVE:
        begin
          if (hw.move_done && !move_done_q)
          begin
            cyl      <= tgt;
            home_run <= 1'b0;
            pos_cnt  <= 32'h1;
            pos      <= POS_SETTLE;
          end
          else if (pos_cnt <= 32'h1)
          begin
            seek_err <= 1'b1;
            home_run <= 1'b0;
            pos      <= POS_IDLE;
          end
          else
            pos_cnt <= pos_cnt - 32'h1;
        end
        POS_SETTLE:
        begin
          if (offset_chg)
            pos_cnt <= 32'(OFFSET_SETTLE_CYC);
          else if (pos_cnt <= 32'h1)
          begin
            head_chg <= 1'b0;
            pos      <= POS_IDLE;
          end
          else
            pos_cnt <= pos_cnt - 32'h1;
        end
        default:
          pos <= POS_IDLE;
      endcase
      // hardware error beats a same-cycle clear from the homing command
      if (hw.carriage_out_of_field || hw.heads_out_of_zone)
        seek_err <= 1'b1;
    end
  end

  // heads positioned only when idle with no offset change pending
  assign status_o.heads_positioned = pos == POS_IDLE && !offset_chg &&
                                     !seek_err;
  assign status_o.seek_error = seek_err;
  assign status_o.fault      = fault;
  assign status_o.retract    = retract;
  assign move_cyl_o          = tgt;
  assign head_o              = head;

  // fault causes; interface misuse outside the servo area only
  always_comb
  begin
    next_cause    = 8'h00;
    next_cause[0] = !hw.servo_area && (
                    (wen && ren) ||
                    ((wen || ren) && !status_o.heads_positioned) ||
                    ((wen || ren) && head_pending) ||
                    (wen && hw.write_protect) ||
                    (wen && hw.servo_unrecoverable));
    next_cause[1] = hw.head_open_short || hw.write_current_lost ||
                    (wen && hw.write_data_missing);
    next_cause[2] = hw.servo_int_wen || (hw.servo_area &&
                    !(hw.servo_seen_a && hw.servo_seen_b));
    next_cause[3] = hw.servo_fields_absent || hw.pos_supply_unsafe ||
                    hw.retract_store_low;
    next_cause[4] = hw.osc_unlock || hw.spindle_speed_bad ||
                    hw.selftest_fail;
  end
  assign hw_cause = |next_cause[4:1];

  // fault latch; a live cause beats a clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fault   <= 1'b0;
      cause   <= 8'h00;
      retract <= 1'b0;
    end
    else
    begin
      if (|next_cause)
      begin
        fault <= 1'b1;
        cause <= cause | next_cause;
      end
      else if (clr_fire)
      begin
        fault <= 1'b0;
        cause <= 8'h00;
      end
      if (|next_cause[3:1])
        retract <= 1'b1;
      else if (clr_fire && !hw_cause)
        retract <= 1'b0;
    end
  end

  // marker timing: sector length from the configured count
  assign sect_len = ctrl[0] ? 32'(REV_CYC / SECT_ALT) : 32'(REV_CYC / SECT_FULL);
  assign mark_start = sect_cnt == 32'h0 &&
                      !(head_chg && pos != POS_IDLE);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rev_cnt       <= 32'h0;
      sect_cnt      <= 32'h0;
      mark_cnt      <= 6'h00;
      rev_mark_o    <= 1'b0;
      sector_mark_o <= 1'b0;
    end
    else
    begin
      rev_cnt  <= (rev_cnt >= 32'(REV_CYC - 1)) ? 32'h0 : rev_cnt + 32'h1;
      sect_cnt <= (rev_cnt >= 32'(REV_CYC - 1) || sect_cnt >= sect_len - 32'h1)
                  ? 32'h0 : sect_cnt + 32'h1;
      if (mark_start && mark_cnt == 6'h00)
      begin
        mark_cnt      <= 6'(MARK_CYC - 1);
        rev_mark_o    <= rev_cnt == 32'h0;
        sector_mark_o <= rev_cnt != 32'h0;
      end
      else if (mark_cnt != 6'h00)
        mark_cnt <= mark_cnt - 6'h01;
      else
      begin
        rev_mark_o    <= 1'b0;
        sector_mark_o <= 1'b0;
      end
    end
  end

  // wishbone: one wait state, unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      ctrl     <= CTRL_RESET;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      // a write lands at the edge that sees the answer
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] &&
          wb_adr_i == REG_CTRL)
        ctrl <= wb_dat_i[1:0];
      if (wb_cyc_i && wb_stb_i && !wb_ack_o)
      begin
        case (wb_adr_i)
          REG_CTRL:   wb_dat_o <= {30'h0, ctrl};
          REG_STATUS: wb_dat_o <= {24'h0, head_pending, home_run, head,
                                   status_o};
          REG_CYL:    wb_dat_o <= {22'h0, cyl};
          REG_CAUSE:  wb_dat_o <= {24'h0, cause};
          default:    wb_dat_o <= 32'h0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- verilog/ddcs_pkg.sv
// constants and carrier types for the drive control and status block
package ddcs_pkg;

  // clock
  localparam int unsigned CLK_MHZ = 20;

  // documented times
  localparam int unsigned MIN_PULSE_NS    = 300;
  localparam int unsigned HOME_PULSE_MAX_US = 1000;
  localparam int unsigned MARK_NS         = 1250;
  localparam int unsigned OFFSET_MAX_US   = 2000;
  localparam int unsigned FAULT_CLR_MAX_US = 2000;
  localparam int unsigned ZERO_SEEK_MAX_US = 1500;
  localparam int unsigned HEAD_SEEK_MAX_MS = 10;
  localparam int unsigned MOVE_MAX_MS     = 500;
  localparam int unsigned BAD_CYL_MAX_US  = 1500;
  localparam int unsigned REV_PER_MIN     = 3510;

  // derived cycle counts (least times round up, longest round down)
  localparam int unsigned MIN_PULSE_CYC = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MARK_CYC      = (MARK_NS * CLK_MHZ) / 1000;
  localparam int unsigned OFFSET_MAX_CYC    = OFFSET_MAX_US * CLK_MHZ;
  localparam int unsigned ZERO_SEEK_MAX_CYC = ZERO_SEEK_MAX_US * CLK_MHZ;
  localparam int unsigned HEAD_SEEK_MAX_CYC = HEAD_SEEK_MAX_MS * 1000 * CLK_MHZ;
  localparam int unsigned MOVE_MAX_CYC      = MOVE_MAX_MS * 1000 * CLK_MHZ;
  localparam int unsigned REV_CYC = (60 * 1000000 * CLK_MHZ) / REV_PER_MIN;

  // control bus bit positions under the control-select strobe
  localparam int unsigned BIT_WRITE     = 0;
  localparam int unsigned BIT_READ      = 1;
  localparam int unsigned BIT_OFS_PLUS  = 2;
  localparam int unsigned BIT_OFS_MINUS = 3;
  localparam int unsigned BIT_FAULT_CLR = 4;
  localparam int unsigned BIT_HOME      = 6;
  localparam int unsigned BIT_EARLY     = 7;
  localparam int unsigned BIT_LATE      = 8;

  // geometry
  localparam int unsigned BUS_W      = 10;
  localparam logic [9:0]  MAX_CYL    = 10'h0cd;
  localparam int unsigned SECT_FULL  = 64;
  localparam int unsigned SECT_ALT   = 32;

  // register map (byte addresses)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CYL    = 4'h8;
  localparam logic [3:0] REG_CAUSE  = 4'hc;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // conditions reported by the drive hardware
  typedef struct packed {
    logic head_open_short;
    logic write_current_lost;
    logic write_data_missing;
    logic servo_int_wen;
    logic servo_seen_a;
    logic servo_seen_b;
    logic servo_fields_absent;
    logic pos_supply_unsafe;
    logic retract_store_low;
    logic osc_unlock;
    logic spindle_speed_bad;
    logic heads_out_of_zone;
    logic selftest_fail;
    logic carriage_out_of_field;
    logic write_protect;
    logic servo_unrecoverable;
    logic servo_area;
    logic move_done;
  } ddcs_hw_type;

  // status lines to the controller
  typedef struct packed {
    logic fault;
    logic seek_error;
    logic heads_positioned;
    logic retract;
  } ddcs_status_type;

endpackage

//--- verilog/ddcs_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ddcs_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // raw and clean levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  if (W < 1) $error("ddcs_sync: width must be positive");

  // shift chain; a bit moves once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1  <= '0;
      s2  <= '0;
      s3  <= '0;
      q_o <= '0;
    end
    else
    begin
      s1  <= d_i;
      s2  <= s1;
      s3  <= s2;
      q_o <= (s2 & s3) | (q_o & (s2 | s3));
    end
  end
endmodule
`default_nettype wire

//--- tb/ddcs_chk.sv
// assertion checker bound to the drive control and status block
`timescale 1ns/1ps
`default_nettype none
module ddcs_chk (
  // clock and reset
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  // bus handshake
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_ack_o,
  // drive side outputs
  input wire logic                      read_data_en_o,
  input wire logic                      read_sync_start_o,
  input wire logic                      strobe_early_o,
  input wire logic                      strobe_late_o,
  input wire logic                      write_drive_o,
  input wire logic                      move_start_o,
  input wire logic [9:0]                move_cyl_o,
  input wire ddcs_pkg::ddcs_status_type status_o,
  input wire logic                      rev_mark_o,
  input wire logic                      sector_mark_o
);
  import ddcs_pkg::*;
  logic [5:0] rev_w;
  logic [5:0] sec_w;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cycles each marker has been high so far
  always_ff @(posedge clk_i)
  begin
    rev_w <= (rst_i || !rev_mark_o) ? 6'h00 : rev_w + 6'h01;
    sec_w <= (rst_i || !sector_mark_o) ? 6'h00 : sec_w + 6'h01;
  end
  // request and its one-cycle answer
  sequence wb_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence wb_ans_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_wb_answer_once: assert property (wb_req_s |=> wb_ans_s)
    else $error("bus answer missing or too long");
  chk_rev_mark_width: assert property (
    $fell(rev_mark_o) |-> rev_w == MARK_CYC)
    else $error("revolution marker width wrong");
  chk_sec_mark_width: assert property (
    $fell(sector_mark_o) |-> sec_w == MARK_CYC)
    else $error("sector marker width wrong");
  chk_marks_apart: assert property (!(rev_mark_o && sector_mark_o))
    else $error("sector marker overlaps revolution marker");
  chk_read_sync_rise: assert property (
    $rose(read_data_en_o) |-> read_sync_start_o)
    else $error("read enable without sync start");
  chk_strobe_read_only: assert property (
    (strobe_early_o || strobe_late_o) |-> read_data_en_o)
    else $error("strobe shift outside a read");
  chk_fault_no_write: assert property (
    status_o.fault [*2] |-> !write_drive_o)
    else $error("write driver on during fault");
  chk_move_cyl_legal: assert property (
    move_start_o |-> move_cyl_o <= MAX_CYL)
    else $error("move to illegal cylinder");
  chk_move_unpositioned: assert property (
    move_start_o |-> !status_o.heads_positioned)
    else $error("heads positioned during move start");
endmodule
bind ddcs_top ddcs_chk i_ddcs_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .read_data_en_o(read_data_en_o),
  .read_sync_start_o(read_sync_start_o), .strobe_early_o(strobe_early_o),
  .strobe_late_o(strobe_late_o), .write_drive_o(write_drive_o),
  .move_start_o(move_start_o), .move_cyl_o(move_cyl_o),
  .status_o(status_o), .rev_mark_o(rev_mark_o),
  .sector_mark_o(sector_mark_o)
);
`default_nettype wire

//--- tb/ddcs_ctl_model.sv
// disk controller model driving tag strobes and bus bits
`timescale 1ns/1ps
`default_nettype none
module ddcs_ctl_model (
  // clock
  input  wire logic       clk_i,
  // tag strobes and bus bits
  output wire logic       cyl_tag_o,
  output wire logic       head_tag_o,
  output wire logic       ctl_tag_o,
  output wire logic [9:0] bus_o
);
  logic [2:0] tags = 3'b000;
  logic [9:0] val  = 10'h000;
  logic       drv  = 1'b0;
  // a released bus shows the inverse of its last value
  assign bus_o      = drv ? val : ~val;
  assign cyl_tag_o  = tags[0];
  assign head_tag_o = tags[1];
  assign ctl_tag_o  = tags[2];
  // one tag operation: bus first, strobe held n cycles, then release
  task automatic op(input int k, input logic [9:0] v, input int n);
    @(posedge clk_i);
    val <= v;
    drv <= 1'b1;
    @(posedge clk_i);
    tags <= 3'b001 << k;
    repeat (n) @(posedge clk_i);
    tags <= 3'b000;
    @(posedge clk_i);
    drv <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the drive control and status block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ddcs_pkg::*;
  localparam int OFS = 50;
  localparam int RVC = 8192;
  localparam int MTO = 200;
  logic            clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            req, we, ack, ms, wdrv, rd_en, rd_sy, st_e, st_l;
  logic            rev_m, sec_m, cyl_t, head_t, ctl_t;
  logic [3:0]      adr;
  logic [31:0]     wdat, rdat, rd;
  logic [9:0]      bus, mcyl;
  logic [1:0]      head;
  logic [7:0]      mv_cnt = 8'h00;
  ddcs_hw_type     hw_set, hw_in;
  ddcs_status_type st;
  int              miscompares = 0;
  int              tests_run = 0;
  int              cycles = 0;
  int              moves = 0;
  int              n, s;
  logic [9:0]      rd_bits [3] = '{10'h2a2, 10'h322, 10'h2a0};
  logic [2:0]      rd_exp [3] = '{3'b110, 3'b101, 3'b000};
  ddcs_top #(.OFFSET_SETTLE_CYC(OFS), .ZERO_SEEK_CYC(50),
    .HEAD_SEEK_CYC(80), .MOVE_TIMEOUT_CYC(MTO), .REV_CYC(RVC)) i_ddcs_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .cyl_tag_i(cyl_t), .head_tag_i(head_t),
    .ctl_tag_i(ctl_t), .bus_i(bus), .hw_i(hw_in), .move_start_o(ms),
    .move_cyl_o(mcyl), .head_o(head), .write_drive_o(wdrv),
    .read_data_en_o(rd_en), .read_sync_start_o(rd_sy),
    .strobe_early_o(st_e), .strobe_late_o(st_l), .status_o(st),
    .rev_mark_o(rev_m), .sector_mark_o(sec_m));
  ddcs_ctl_model i_ddcs_ctl_model (.clk_i(clk_i), .cyl_tag_o(cyl_t),
    .head_tag_o(head_t), .ctl_tag_o(ctl_t), .bus_o(bus));
  always #25 clk_i = ~clk_i;
  // positioner: arrives ten cycles after each move start
  always @(posedge clk_i)
  begin
    mv_cnt <= ms ? 8'h0a : (mv_cnt != 8'h00) ? mv_cnt - 8'h01 : mv_cnt;
    moves <= moves + int'(ms);
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      miscompares = miscompares + 1;
      close_out();
    end
  end
  always_comb
  begin
    hw_in = hw_set;
    hw_in.move_done = (mv_cnt == 8'h00);
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // single classic bus cycle, held until ack is sampled
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
    int k;
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    rd = rdat;
    req <= 1'b0;
    miscompares += int'(k == 50);
  endtask
  task automatic wait_st(input int b, input logic v, input int lim);
    n = 0;
    while (st[b] !== v && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask
  // cycles between two revolution markers and sector markers between
  task automatic measure();
    logic pr, ps;
    int t0;
    t0 = -1;
    n = 0;
    s = 0;
    pr = 1'b1;
    ps = 1'b1;
    for (int i = 0; i < 2 * RVC + 50 && n == 0; i++)
    begin
      @(posedge clk_i);
      if (rev_m === 1'b1 && pr === 1'b0 && t0 >= 0)
        n = i - t0;
      if (rev_m === 1'b1 && pr === 1'b0 && t0 < 0)
        t0 = i;
      s += int'(t0 >= 0 && n == 0 && sec_m === 1'b1 && ps === 1'b0);
      pr = rev_m;
      ps = sec_m;
    end
  endtask
  initial
  begin
    {req, we, adr, wdat} = '0;
    hw_set = '0;
    hw_set.servo_seen_a = 1'b1;
    hw_set.servo_seen_b = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, read-only and unmapped places
    check("status", st, 4'b0010);
    xfer(1'b1, REG_STATUS, 32'hff);
    xfer(1'b0, REG_STATUS, 32'h0);
    check("reg_status", rd, 32'h2);
    xfer(1'b0, 4'h2, 32'h0);
    check("unmapped", rd, 32'h0);
    // markers in both sector modes
    for (int m = 0; m < 2; m++)
    begin
      xfer(1'b1, REG_CTRL, m);
      measure();
      check("rev_period", n, RVC);
      check("sectors", s, m ? SECT_ALT - 1 : SECT_FULL - 1);
    end
    xfer(1'b1, REG_CTRL, 32'h0);
    // read window with strobe shifts, ignored bits set
    for (int j = 0; j < 3; j++)
    begin
      s = 0;
      fork
        i_ddcs_ctl_model.op(2, rd_bits[j], 30);
        begin
          repeat (20) @(posedge clk_i) s += int'(rd_sy);
          check("read_levels", {rd_en, st_e, st_l}, rd_exp[j]);
          check("ignored_bits", st, 4'b0010);
        end
      join
      check("sync_pulses", s, j < 2);
    end
    // offset change drops and restores positioned
    fork
      i_ddcs_ctl_model.op(2, 10'h004, 10);
      begin
        wait_st(1, 1'b0, 20);
        check("offset_drop", st[1], 1'b0);
      end
    join
    wait_st(1, 1'b1, 2 * OFS + 60);
    check("offset_back", st, 4'b0010);
    // write on protected volume faults, clear pulse removes it
    hw_set.write_protect <= 1'b1;
    fork
      i_ddcs_ctl_model.op(2, 10'h001, 12);
      begin
        repeat (10) @(posedge clk_i);
        check("write_blocked", wdrv, 1'b0);
      end
    join
    check("fault_set", st.fault, 1'b1);
    xfer(1'b0, REG_CAUSE, 32'h0);
    check("cause", rd, 32'h1);
    hw_set.write_protect <= 1'b0;
    i_ddcs_ctl_model.op(2, 10'h010, MIN_PULSE_CYC + 2);
    wait_st(3, 1'b0, FAULT_CLR_MAX_US * CLK_MHZ);
    check("fault_clear", st, 4'b0010);
    // head select then legal seek
    i_ddcs_ctl_model.op(1, 10'h003, 8);
    fork
      i_ddcs_ctl_model.op(0, 10'h00a, 8);
      begin
        wait_st(1, 1'b0, 40);
        check("seek_drop", st[1], 1'b0);
      end
    join
    wait_st(1, 1'b1, 400);
    check("seek_head", head, 2'h3);
    check("seek_cyl", mcyl, 10'h00a);
    // illegal cylinder, then a refused seek
    s = moves;
    i_ddcs_ctl_model.op(0, 10'h0ce, 8);
    wait_st(2, 1'b1, BAD_CYL_MAX_US * CLK_MHZ);
    check("bad_cyl", st[2], 1'b1);
    i_ddcs_ctl_model.op(0, 10'h005, 8);
    repeat (20) @(posedge clk_i);
    check("no_move", moves, s);
    // return to track zero clears the error at once, stays low while moving
    fork
      i_ddcs_ctl_model.op(2, 10'h040, 10);
      begin
        @(posedge clk_i iff ms === 1'b1);
        repeat (5) @(posedge clk_i);
        check("home_low", st[2:1], 2'b00);
      end
    join
    wait_st(1, 1'b1, MTO + 100);
    check("home_done", st, 4'b0010);
    check("home_head", head, 2'h0);
    xfer(1'b0, REG_CYL, 32'h0);
    check("home_cyl", rd, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
